// ### design/dtgp_pkg.sv
// ****************************************************************
// shared constants and carriers for the dual timer front end
// ****************************************************************
package dtgp_pkg;

    // special function register addresses
    localparam logic [7:0] DTGP_ADDR_GATE_MODE = 8'h89; // timer_pair_gate_mode_cfg
    localparam logic [7:0] DTGP_ADDR_PRESCALE = 8'h99;  // timer_pair_prescale_cfg
    localparam logic [7:0] DTGP_ADDR_TCTL_A = 8'h9a;    // timer a control
    localparam logic [7:0] DTGP_ADDR_TCTL_B = 8'h9b;    // timer b control

    // reset values
    localparam logic [7:0] DTGP_RST_GATE_MODE = 8'h00; // all gating and modes off
    localparam logic [7:0] DTGP_RST_PRESCALE = 8'h00;  // divide by one
    localparam logic [7:0] DTGP_RST_TCTL = 8'h00;      // stopped, count up

    // gate and mode register field positions
    localparam int DTGP_POS_GATE_B = 6;   // timer_b_gate_enable
    localparam int DTGP_POS_GATE_A = 5;   // timer_a_gate_enable
    localparam int DTGP_POS_SRC_B = 4;    // timer_b_source_select
    localparam int DTGP_POS_OE_B = 3;     // timer_b_pin_out_enable
    localparam int DTGP_POS_SPLIT_B = 2;  // timer_b_split_mode
    localparam int DTGP_POS_OE_A = 1;     // timer_a_pin_out_enable
    localparam int DTGP_POS_SPLIT_A = 0;  // timer_a_split_mode
    localparam int DTGP_POS_UNUSED = 7;   // reads as zero

    // prescale register nibbles
    localparam int DTGP_POS_PRE_B = 4;    // timer_b_prescale_code low bit
    localparam int DTGP_POS_PRE_A = 0;    // timer_a_prescale_code low bit
    localparam int DTGP_PRE_W = 4;        // code width

    // prescaler limits
    localparam logic [3:0] DTGP_PRE_MAX_CODE = 4'he; // codes above act as this
    localparam int DTGP_PRE_CNT_W = 14;               // up to 16384

    // count limits
    localparam logic [15:0] DTGP_CNT_TOP = 16'hffff;  // up wrap point
    localparam logic [15:0] DTGP_CNT_BOT = 16'h0000;  // down wrap point
    localparam logic [7:0] DTGP_BYTE_TOP = 8'hff;     // split mode up wrap
    localparam logic [7:0] DTGP_BYTE_BOT = 8'h00;     // split mode down wrap

    // per timer control register layout, msb first
    typedef struct packed {
        logic rollover_flag;      // overflow flag, bit 7
        logic ext_flag;           // stored only
        logic count_down_enable;  // direction, bit 5
        logic toggle_out;         // output mode, bit 4
        logic ext_enable;         // stored only
        logic run;                // run, bit 2
        logic event_count_enable; // count pin edges, bit 1
        logic reload_capture;     // stored only
    } dtgp_tctl_type;

    // special function register access
    typedef struct packed {
        logic [7:0] addr;  // register address
        logic wr;          // write strobe
        logic rd;          // read strobe
        logic [7:0] wdata; // write data
    } dtgp_sfr_type;

endpackage

// ### design/dtgp_prescaler.sv
`timescale 1ns/1ns
// ****************************************************************
// power of two prescaler as a clock enable strobe
// ****************************************************************
module dtgp_prescaler #(
    parameter int CNT_W = dtgp_pkg::DTGP_PRE_CNT_W // divider counter width
) (
    input wire logic sys_clk,          // system clock
    input wire logic sys_rst,          // sync reset, active high
    input wire logic clk_en,           // freezes state while low
    input wire logic [3:0] code,       // division code
    input wire logic tick_in,          // input tick
    output logic stb                   // one cycle divided tick
);
    import dtgp_pkg::*;

    logic [CNT_W-1:0] cnt_q;   // ticks seen
    logic [CNT_W-1:0] cnt_d;   // next tick count
    logic [CNT_W-1:0] limit;   // last count before strobe
    logic [3:0] eff_code;      // code with top code folded

    // strobe and next count; a strobe, not a derived clock
    always_comb begin
        eff_code = (code > DTGP_PRE_MAX_CODE) ? DTGP_PRE_MAX_CODE : code;
        limit = CNT_W'((32'h1 << eff_code) - 32'h1);
        stb = tick_in && (cnt_q >= limit);
        cnt_d = cnt_q;
        if (tick_in) begin
            cnt_d = stb ? '0 : cnt_q + CNT_W'(1);
        end
    end

    // register the count
    always_ff @(posedge sys_clk) begin
        if (sys_rst) begin
            cnt_q <= '0;
        end else if (clk_en) begin
            cnt_q <= cnt_d;
        end
    end

    a_div_one: assert property (@(posedge sys_clk) disable iff (sys_rst)
        (code == 4'h0 && tick_in) |-> stb)
        else $error("code zero did not pass every tick");

    a_div_top: assert property (@(posedge sys_clk) disable iff (sys_rst)
        (stb && code >= DTGP_PRE_MAX_CODE) |-> (cnt_q == 14'h3fff))
        else $error("top codes must divide by 16384");

endmodule

// ### design/dtgp_top.sv
`timescale 1ns/1ns
// ****************************************************************
// dual timer gating, clock source, split mode and prescale front end
// ****************************************************************
// What this block does
// - gate enable: count only while gate pin high
// - timer b source: system clock or a overflow
// - timer a timer mode: prescaled system clock only
// - timer b output reaches pin only when enabled
// - timer a output reaches pin only when enabled
// - split bit: one 16-bit or two 8-bit
// - prescale register: b upper nibble, a lower
// - divide by two to code, top code 16384
// - overflow output pulses or toggles per mode
// - timers chain into longer counters
// - each timer counts up or down
// - each timer has count and gate pins
// - timer advances only while run set
// - overflow flag set on wrap, software clears while running
// - counter mode steps on count pin falls
// - count up by default, down when enabled
module dtgp_top (
    input wire logic sys_clk,                    // system clock, 10 MHz
    input wire logic sys_rst,                    // sync reset, active high
    input wire logic clk_en,                     // freezes all state while low
    input wire dtgp_pkg::dtgp_sfr_type sfr,      // register access from the core
    output logic [7:0] sfr_rdata,                // registered read data
    input wire logic ext_gate_pin_a,             // timer a gating pin
    input wire logic ext_gate_pin_b,             // timer b gating pin
    input wire logic count_input_pin_a,          // timer a count pin
    input wire logic count_input_pin_b,          // timer b count pin
    output logic [15:0] timer_a_count,           // timer a value
    output logic [15:0] timer_b_count,           // timer b value
    output logic timer_a_out,                    // timer a output pin level
    output logic timer_a_out_en,                 // timer a pin drive enable
    output logic timer_b_out,                    // timer b output pin level
    output logic timer_b_out_en,                 // timer b pin drive enable
    output logic timer_a_irq_req,                // timer a interrupt request pulse
    output logic timer_b_irq_req                 // timer b interrupt request pulse
);
    import dtgp_pkg::*;

    // ****************************************************************
    // registers
    // ****************************************************************
    logic [7:0] gate_mode_q;        // timer_pair_gate_mode_cfg
    logic [7:0] gate_mode_d;        // next gate and mode config
    logic [7:0] prescale_q;         // timer_pair_prescale_cfg
    logic [7:0] prescale_d;         // next prescale config
    dtgp_tctl_type tctl_q [2];      // per timer control
    dtgp_tctl_type tctl_d [2];      // next per timer control
    logic [7:0] rdata_q;            // read data
    logic [7:0] rdata_d;            // next read data

    // ****************************************************************
    // timer state
    // ****************************************************************
    logic [15:0] cnt_q [2];         // counts
    logic [15:0] cnt_d [2];         // next counts
    logic [1:0] pin_prev_q;         // count pin last level
    logic [1:0] pin_prev_d;         // next count pin level
    logic [1:0] out_q;              // output levels
    logic [1:0] out_d;              // next output levels
    logic [1:0] oe_q;               // pin enables
    logic [1:0] oe_d;               // next pin enables
    logic [1:0] irq_q;              // interrupt request pulses
    logic [1:0] irq_d;              // next request pulses

    // ****************************************************************
    // per timer decoded controls and events
    // ****************************************************************
    logic [1:0] gate_en;            // gate_enable_bit per timer
    logic [1:0] gate_pin;           // ext_gate_pin per timer
    logic [1:0] split;              // split_mode_bit per timer
    logic [1:0] pin_oe;             // pin out enable per timer
    logic [3:0] pre_code [2];       // prescale codes
    logic [1:0] pre_tick;           // ticks into prescalers
    logic [1:0] pre_stb;            // prescaler strobes
    logic [1:0] fall;               // count pin falling edges
    logic [1:0] step;               // timer advances this cycle
    logic [1:0] ovf_evt;            // wrap this cycle
    logic [1:0] ctl_wr;             // control register written
    logic [1:0] pin_now;            // count pin levels

    // field decode and clock selection
    always_comb begin
        gate_en = {gate_mode_q[DTGP_POS_GATE_B], gate_mode_q[DTGP_POS_GATE_A]};
        gate_pin = {ext_gate_pin_b, ext_gate_pin_a};
        pin_now = {count_input_pin_b, count_input_pin_a};
        split = {gate_mode_q[DTGP_POS_SPLIT_B], gate_mode_q[DTGP_POS_SPLIT_A]};
        pin_oe = {gate_mode_q[DTGP_POS_OE_B], gate_mode_q[DTGP_POS_OE_A]};
        pre_code[0] = prescale_q[DTGP_POS_PRE_A +: DTGP_PRE_W];
        pre_code[1] = prescale_q[DTGP_POS_PRE_B +: DTGP_PRE_W];
        fall = pin_prev_q & ~pin_now;
        // timer a has no other clock in timer mode
        pre_tick[0] = 1'b1;
        // timer b from system clock or timer a wrap, which chains them
        pre_tick[1] = gate_mode_q[DTGP_POS_SRC_B] ? ovf_evt[0] : 1'b1;
    end

    // ****************************************************************
    // prescalers
    // ****************************************************************
    dtgp_prescaler #(.CNT_W(DTGP_PRE_CNT_W)) u_pre_a (
        .sys_clk(sys_clk),
        .sys_rst(sys_rst),
        .clk_en(clk_en),
        .code(pre_code[0]),
        .tick_in(pre_tick[0]),
        .stb(pre_stb[0])
    );

    dtgp_prescaler #(.CNT_W(DTGP_PRE_CNT_W)) u_pre_b (
        .sys_clk(sys_clk),
        .sys_rst(sys_rst),
        .clk_en(clk_en),
        .code(pre_code[1]),
        .tick_in(pre_tick[1]),
        .stb(pre_stb[1])
    );

    // ****************************************************************
    // counting, overflow, outputs and register access
    // ****************************************************************
    always_comb begin
        gate_mode_d = gate_mode_q;
        prescale_d = prescale_q;
        rdata_d = rdata_q;
        pin_prev_d = pin_now;
        irq_d = 2'b00;
        ctl_wr = 2'b00;
        // register writes; unused addresses are ignored
        if (sfr.wr) begin
            if (sfr.addr == DTGP_ADDR_GATE_MODE) begin
                gate_mode_d = sfr.wdata;
                gate_mode_d[DTGP_POS_UNUSED] = 1'b0;
            end else if (sfr.addr == DTGP_ADDR_PRESCALE) begin
                prescale_d = sfr.wdata;
            end else if (sfr.addr == DTGP_ADDR_TCTL_A) begin
                ctl_wr[0] = 1'b1;
            end else if (sfr.addr == DTGP_ADDR_TCTL_B) begin
                ctl_wr[1] = 1'b1;
            end
        end
        // reads return the value before any same cycle write
        if (sfr.rd) begin
            if (sfr.addr == DTGP_ADDR_GATE_MODE) begin
                rdata_d = {1'b0, gate_mode_q[6:0]};
            end else if (sfr.addr == DTGP_ADDR_PRESCALE) begin
                rdata_d = prescale_q;
            end else if (sfr.addr == DTGP_ADDR_TCTL_A) begin
                rdata_d = tctl_q[0];
            end else if (sfr.addr == DTGP_ADDR_TCTL_B) begin
                rdata_d = tctl_q[1];
            end else begin
                rdata_d = 8'h00;
            end
        end
        for (int i = 0; i < 2; i++) begin
            cnt_d[i] = cnt_q[i];
            out_d[i] = 1'b0;
            // counter mode uses pin falls, timer mode the prescaled tick
            step[i] = (tctl_q[i].event_count_enable ? fall[i] : pre_stb[i])
                && tctl_q[i].run
                && (!gate_en[i] || gate_pin[i]);
            ovf_evt[i] = 1'b0;
            if (step[i]) begin
                if (tctl_q[i].count_down_enable) begin
                    if (split[i]) begin
                        ovf_evt[i] = (cnt_q[i][7:0] == DTGP_BYTE_BOT);
                        cnt_d[i] = {cnt_q[i][15:8] - 8'h01, cnt_q[i][7:0] - 8'h01};
                    end else begin
                        ovf_evt[i] = (cnt_q[i] == DTGP_CNT_BOT);
                        cnt_d[i] = cnt_q[i] - 16'h0001;
                    end
                end else begin
                    if (split[i]) begin
                        ovf_evt[i] = (cnt_q[i][7:0] == DTGP_BYTE_TOP);
                        cnt_d[i] = {cnt_q[i][15:8] + 8'h01, cnt_q[i][7:0] + 8'h01};
                    end else begin
                        ovf_evt[i] = (cnt_q[i] == DTGP_CNT_TOP);
                        cnt_d[i] = cnt_q[i] + 16'h0001;
                    end
                end
            end
            // control register; one sets the flag, zero clears it only while running
            tctl_d[i] = tctl_q[i];
            if (ctl_wr[i]) begin
                tctl_d[i] = sfr.wdata;
                tctl_d[i].rollover_flag = sfr.wdata[7]
                    || (tctl_q[i].rollover_flag && !tctl_q[i].run);
                irq_d[i] = sfr.wdata[7];
            end
            // hardware set beats a software clear
            if (ovf_evt[i]) begin
                tctl_d[i].rollover_flag = 1'b1;
                irq_d[i] = 1'b1;
            end
            // pulse or toggle, held low when the pin is not enabled
            if (tctl_q[i].toggle_out) begin
                out_d[i] = out_q[i] ^ ovf_evt[i];
            end else begin
                out_d[i] = ovf_evt[i];
            end
            out_d[i] = out_d[i] && pin_oe[i];
            oe_d[i] = pin_oe[i];
        end
    end

    // register all state
    always_ff @(posedge sys_clk) begin
        if (sys_rst) begin
            gate_mode_q <= DTGP_RST_GATE_MODE;
            prescale_q <= DTGP_RST_PRESCALE;
            tctl_q[0] <= DTGP_RST_TCTL;
            tctl_q[1] <= DTGP_RST_TCTL;
            rdata_q <= 8'h00;
            cnt_q[0] <= 16'h0000;
            cnt_q[1] <= 16'h0000;
            pin_prev_q <= 2'b00;
            out_q <= 2'b00;
            oe_q <= 2'b00;
            irq_q <= 2'b00;
        end else if (clk_en) begin
            gate_mode_q <= gate_mode_d;
            prescale_q <= prescale_d;
            tctl_q[0] <= tctl_d[0];
            tctl_q[1] <= tctl_d[1];
            rdata_q <= rdata_d;
            cnt_q[0] <= cnt_d[0];
            cnt_q[1] <= cnt_d[1];
            pin_prev_q <= pin_prev_d;
            out_q <= out_d;
            oe_q <= oe_d;
            irq_q <= irq_d;
        end
    end

    // outputs straight from flops
    assign sfr_rdata = rdata_q;
    assign timer_a_count = cnt_q[0];
    assign timer_b_count = cnt_q[1];
    assign timer_a_out = out_q[0];
    assign timer_b_out = out_q[1];
    assign timer_a_out_en = oe_q[0];
    assign timer_b_out_en = oe_q[1];
    assign timer_a_irq_req = irq_q[0];
    assign timer_b_irq_req = irq_q[1];

    // ****************************************************************
    // checks
    // ****************************************************************
    default clocking @(posedge sys_clk); endclocking
    default disable iff (sys_rst);

    sequence s_wrap_a;
        clk_en && ovf_evt[0];
    endsequence

    a_gate_hold: assert property ((clk_en && gate_en[0] && !ext_gate_pin_a)
        |=> $stable(cnt_q[0])) else $error("gated timer a moved");
    a_run_hold: assert property ((clk_en && !tctl_q[1].run)
        |=> $stable(cnt_q[1])) else $error("stopped timer b moved");
    a_chain_step: assert property (((clk_en && gate_mode_q[DTGP_POS_SRC_B]
        && pre_code[1] == 4'h0 && tctl_q[1].run && !gate_en[1]
        && !tctl_q[1].event_count_enable) and s_wrap_a) |=> !$stable(cnt_q[1]))
        else $error("timer b did not take timer a wrap");
    a_wrap_flag: assert property (s_wrap_a |=> tctl_q[0].rollover_flag
        && timer_a_irq_req) else $error("wrap did not set flag");
    a_pulse_out: assert property ((s_wrap_a and (!tctl_q[0].toggle_out
        && pin_oe[0])) |=> timer_a_out) else $error("no pulse on wrap");
    a_toggle_out: assert property ((s_wrap_a and (tctl_q[0].toggle_out
        && pin_oe[0])) |=> timer_a_out != $past(timer_a_out))
        else $error("no toggle on wrap");
    a_oe_follow: assert property ((clk_en && !pin_oe[1]) |=>
        !timer_b_out && !timer_b_out_en) else $error("disabled pin driven");
    a_bit7_zero: assert property ((clk_en && sfr.rd
        && sfr.addr == DTGP_ADDR_GATE_MODE) |=> sfr_rdata[7] == 1'b0)
        else $error("unused bit read back one");
    a_up_count: assert property ((clk_en && step[0] && !split[0]
        && !tctl_q[0].count_down_enable && cnt_q[0] != DTGP_CNT_TOP)
        |=> cnt_q[0] == $past(cnt_q[0]) + 16'h0001) else $error("up step wrong");
    a_event_step: assert property ((clk_en && tctl_q[1].event_count_enable
        && tctl_q[1].run && !gate_en[1] && fall[1]) |=> !$stable(cnt_q[1]))
        else $error("count pin fall missed");

    // a stopped timer keeps its flag on a written zero
    sequence s_clear_a;
        clk_en && ctl_wr[0] && !sfr.wdata[7];
    endsequence

    a_flag_keep: assert property ((s_clear_a and (!tctl_q[0].run
        && !ovf_evt[0])) |=> $stable(tctl_q[0].rollover_flag))
        else $error("stopped timer lost its flag");

    // split mode wraps on the low byte alone
    a_split_wrap: assert property ((clk_en && step[0] && split[0]
        && !tctl_q[0].count_down_enable && cnt_q[0][7:0] == DTGP_BYTE_TOP)
        |=> tctl_q[0].rollover_flag) else $error("byte wrap set no flag");

endmodule

// ### bench/dtgp_pin_model.sv
`timescale 1ns/1ns
// ****************************************************************
// gate and count pins as the board drives them
// ****************************************************************
module dtgp_pin_model (
    input wire logic sys_clk,       // system clock
    output logic ext_gate_pin_a,    // timer a gate level
    output logic ext_gate_pin_b,    // timer b gate level, left high
    output logic count_input_pin_a, // timer a count pin
    output logic count_input_pin_b  // timer b count pin, idles high
);
    // idle high so only commanded pulses give falls
    initial begin
        ext_gate_pin_a = 1'b0;
        ext_gate_pin_b = 1'b1;
        count_input_pin_a = 1'b0;
        count_input_pin_b = 1'b1;
    end
    // keeps moving: a timer in timer mode must ignore it
    always @(posedge sys_clk) begin
        count_input_pin_a <= ~count_input_pin_a;
    end
    // gate level change just after an edge
    task gate(input logic lvl);
        @(posedge sys_clk);
        ext_gate_pin_a <= lvl;
    endtask
    // k falls, two cycles low and two high each
    task pulses(input int k);
        repeat (k) begin
            @(posedge sys_clk);
            count_input_pin_b <= 1'b0;
            repeat (2) @(posedge sys_clk);
            count_input_pin_b <= 1'b1;
            @(posedge sys_clk);
        end
    endtask
endmodule

// ### bench/dtgp_top_bench.sv
`timescale 1ns/1ns
// ****************************************************************
// self checking bench for the dual timer front end
// ****************************************************************
module dtgp_top_bench;
    import dtgp_pkg::*;
    logic sys_clk = 1'b0; // 100 ns period
    logic sys_rst = 1'b1; // held twelve cycles
    logic clk_en = 1'b1; // low freezes the whole block
    dtgp_sfr_type sfr = '0; // register access
    logic [7:0] sfr_rdata;
    logic ext_gate_pin_a, ext_gate_pin_b, count_input_pin_a, count_input_pin_b;
    logic [15:0] timer_a_count, timer_b_count, obs;
    logic timer_a_out, timer_a_out_en, timer_b_out, timer_b_out_en;
    logic timer_a_irq_req, timer_b_irq_req;
    logic [15:0] exp_q[$]; // expected results, oldest first
    string nm_q[$]; // name of each expected result
    logic rd_d = 1'b0; // read taken last edge
    logic snap = 1'b0; // compare a live port value
    logic [1:0] sel = 2'h0; // which live value
    logic [3:0] n_ia = 4'h0, n_oa = 4'h0, n_ib = 4'h0; // pulse tallies
    logic [3:0] ia = 4'h0, oa = 4'h0, ib = 4'h0; // expected tallies
    logic [15:0] ea = 16'h0000, eb = 16'h0000; // expected counts
    int n_errors = 0, n_tests = 0, seed = 39, k;

    always #50 sys_clk = ~sys_clk;

    dtgp_top i_dtgp_top (.sys_clk(sys_clk), .sys_rst(sys_rst), .clk_en(clk_en),
        .sfr(sfr), .sfr_rdata(sfr_rdata), .ext_gate_pin_a(ext_gate_pin_a),
        .ext_gate_pin_b(ext_gate_pin_b), .count_input_pin_a(count_input_pin_a),
        .count_input_pin_b(count_input_pin_b), .timer_a_count(timer_a_count),
        .timer_b_count(timer_b_count), .timer_a_out(timer_a_out),
        .timer_a_out_en(timer_a_out_en), .timer_b_out(timer_b_out),
        .timer_b_out_en(timer_b_out_en), .timer_a_irq_req(timer_a_irq_req),
        .timer_b_irq_req(timer_b_irq_req));
    dtgp_pin_model i_dtgp_pin_model (.sys_clk(sys_clk), .ext_gate_pin_a(ext_gate_pin_a),
        .ext_gate_pin_b(ext_gate_pin_b), .count_input_pin_a(count_input_pin_a),
        .count_input_pin_b(count_input_pin_b));

    // ****************************************************************
    // watcher: takes the oldest note whenever a result shows
    // ****************************************************************
    always_comb begin
        if (sel == 2'h0) begin
            obs = timer_a_count;
        end else if (sel == 2'h1) begin
            obs = timer_b_count;
        end else begin
            obs = {n_ia, n_oa, n_ib, timer_a_out_en, timer_b_out_en, timer_b_out, 1'b0};
        end
    end
    task automatic cmp(input logic [15:0] got);
        logic [15:0] e;
        string s;
        e = exp_q.pop_front();
        s = nm_q.pop_front();
        n_tests++;
        if (got !== e) begin
            n_errors++;
            $display("CHECK FAILED %s expected %h seen %h", s, e, got);
        end
    endtask
    // pulses are tallied so one cycle outputs are never missed
    always @(posedge sys_clk) begin
        rd_d <= sfr.rd;
        if (timer_a_irq_req === 1'b1) n_ia <= n_ia + 4'h1;
        if (timer_a_out === 1'b1) n_oa <= n_oa + 4'h1;
        if (timer_b_irq_req === 1'b1) n_ib <= n_ib + 4'h1;
        if (rd_d) cmp({8'h00, sfr_rdata});
        if (snap) cmp(obs);
    end

    // ****************************************************************
    // drivers
    // ****************************************************************
    task wr(input logic [7:0] a, input logic [7:0] d);
        @(posedge sys_clk);
        sfr.addr <= a;
        sfr.wdata <= d;
        sfr.wr <= 1'b1;
        @(posedge sys_clk);
        sfr.wr <= 1'b0;
    endtask
    task rd(input logic [7:0] a, input logic [7:0] e, input string s);
        @(posedge sys_clk);
        sfr.addr <= a;
        sfr.rd <= 1'b1;
        exp_q.push_back({8'h00, e});
        nm_q.push_back(s);
        @(posedge sys_clk);
        sfr.rd <= 1'b0;
    endtask
    task chk(input logic [1:0] w, input logic [15:0] e, input string s);
        @(posedge sys_clk);
        sel <= w;
        snap <= 1'b1;
        exp_q.push_back(e);
        nm_q.push_back(s);
        @(posedge sys_clk);
        snap <= 1'b0;
    endtask
    // run for k+2 timer edges, then stop (a run-time write clears the flag)
    task go(input logic [7:0] a, input logic [7:0] v, input int k);
        wr(a, v);
        repeat (k) @(posedge sys_clk);
        wr(a, v & 8'hfb);
    endtask
    task wrap_up;
        repeat (3) @(posedge sys_clk);
        if (exp_q.size() != 0) n_errors++;
        $display("checks %0d mismatches %0d", n_tests, n_errors);
        if (n_errors == 0 && n_tests > 0) begin
            $display("TEST PASSED");
        end else begin
            $display("TEST FAILED");
        end
        $finish;
    endtask

    // ****************************************************************
    // main sequence
    // ****************************************************************
    initial begin
        repeat (12) @(posedge sys_clk);
        sys_rst <= 1'b0;
        rd(DTGP_ADDR_GATE_MODE, DTGP_RST_GATE_MODE, "gate_mode");
        rd(DTGP_ADDR_PRESCALE, DTGP_RST_PRESCALE, "prescale");
        rd(DTGP_ADDR_TCTL_A, DTGP_RST_TCTL, "ctl_a");
        rd(DTGP_ADDR_TCTL_B, DTGP_RST_TCTL, "ctl_b");
        rd(8'h55, 8'h00, "unmapped");
        wr(DTGP_ADDR_GATE_MODE, 8'hff);
        rd(DTGP_ADDR_GATE_MODE, 8'h7f, "gate_mode");
        k = $random(seed);
        wr(DTGP_ADDR_PRESCALE, k[7:0]);
        rd(DTGP_ADDR_PRESCALE, k[7:0], "prescale");
        wr(DTGP_ADDR_GATE_MODE, 8'h00);
        $display("test registers done");
        // window of 2^code cycles (2^14 for code 15) holds one strobe; code 0 gets two
        for (int c = 0; c < 16; c++) begin
            wr(DTGP_ADDR_PRESCALE, {4'h0, c[3:0]});
            go(DTGP_ADDR_TCTL_A, 8'h04, ((c == 0) ? 2 : (1 << ((c > 14) ? 14 : c))) - 2);
            ea = ea + ((c == 0) ? 16'h0002 : 16'h0001);
            chk(2'h0, ea, "count_a");
        end
        chk(2'h1, 16'h0000, "count_b");
        wr(DTGP_ADDR_PRESCALE, 8'h00);
        $display("test prescaler done");
        // two running edges counted, six frozen edges must not be
        wr(DTGP_ADDR_TCTL_A, 8'h04);
        clk_en <= 1'b0;
        repeat (6) @(posedge sys_clk);
        clk_en <= 1'b1;
        wr(DTGP_ADDR_TCTL_A, 8'h00);
        k = 3 + ($random(seed) & 31);
        go(DTGP_ADDR_TCTL_A, 8'h04, k);
        ea = ea + k[15:0] + 16'h0004;
        chk(2'h0, ea, "count_a");
        wr(DTGP_ADDR_GATE_MODE, 8'h22);
        go(DTGP_ADDR_TCTL_A, 8'h04, 8);
        chk(2'h0, ea, "count_a");
        i_dtgp_pin_model.gate(1'b1);
        go(DTGP_ADDR_TCTL_A, 8'h04, 8);
        ea = ea + 16'h000a;
        chk(2'h0, ea, "count_a");
        wr(DTGP_ADDR_GATE_MODE, 8'h23);
        go(DTGP_ADDR_TCTL_A, 8'h04, 1);
        ea = ea + 16'h0303;
        chk(2'h0, ea, "count_a");
        $display("test gate and split done");
        // down through zero with pin a enabled
        wr(DTGP_ADDR_GATE_MODE, 8'h02);
        go(DTGP_ADDR_TCTL_A, 8'h24, int'(ea) - 1);
        ea = 16'hffff;
        ia = ia + 4'h1;
        oa = oa + 4'h1;
        chk(2'h0, ea, "count_a");
        chk(2'h2, {ia, oa, ib, 4'b1000}, "pulses");
        // b fed by wraps of a
        wr(DTGP_ADDR_GATE_MODE, 8'h1a);
        wr(DTGP_ADDR_TCTL_B, 8'h04);
        go(DTGP_ADDR_TCTL_A, 8'h04, 0);
        wr(DTGP_ADDR_TCTL_B, 8'h00);
        ea = 16'h0001;
        eb = 16'h0001;
        ia = ia + 4'h1;
        oa = oa + 4'h1;
        chk(2'h0, ea, "count_a");
        chk(2'h1, eb, "count_b");
        $display("test chaining done");
        // toggle output on b, then both pins disabled
        wr(DTGP_ADDR_GATE_MODE, 8'h0a);
        go(DTGP_ADDR_TCTL_B, 8'h34, 0);
        eb = 16'hffff;
        ib = ib + 4'h1;
        chk(2'h1, eb, "count_b");
        chk(2'h2, {ia, oa, ib, 4'b1110}, "pulses");
        wr(DTGP_ADDR_GATE_MODE, 8'h00);
        chk(2'h2, {ia, oa, ib, 4'b0000}, "pulses");
        // count pin falls, slowest prescale must not matter
        wr(DTGP_ADDR_PRESCALE, 8'hf0);
        wr(DTGP_ADDR_TCTL_B, 8'h06);
        k = 1 + ($random(seed) & 7);
        i_dtgp_pin_model.pulses(k);
        wr(DTGP_ADDR_TCTL_B, 8'h00);
        eb = eb + k[15:0];
        ib = ib + 4'h1;
        chk(2'h1, eb, "count_b");
        // software flag set while stopped, clear refused while stopped
        wr(DTGP_ADDR_TCTL_A, 8'h80);
        rd(DTGP_ADDR_TCTL_A, 8'h80, "ctl_a");
        wr(DTGP_ADDR_TCTL_A, 8'h00);
        rd(DTGP_ADDR_TCTL_A, 8'h80, "ctl_a");
        ia = ia + 4'h1;
        chk(2'h2, {ia, oa, ib, 4'b0000}, "pulses");
        $display("test counter and flag done");
        wrap_up();
    end

    // hang guard
    initial begin
        repeat (100000) @(posedge sys_clk);
        n_errors++;
        wrap_up();
    end
endmodule
